// ==== nvmrw_top.sv ====
// Nonvolatile read/write control: registers, sequencer, array port and interrupt
// Function
// - No write starts while write enable is clear.
// - Write trigger launches write; hardware clears it; software only sets it.
// - Every completed write sets the write complete flag.
// - Data write erases then programs low data at low address.
// - Program write halts core, erases, programs high:low word, then resumes.
// - External or watchdog reset during a write sets write error.
// - Warm reset keeps data, address and memory select registers.
// - Memory select picks program or data; frozen while an access runs.
// - Read trigger starts a read, self clears; writing zero does nothing.
// - Control bits six to four read as zero.
// - Write enable clear inhibits starting array writes; a write already running still finishes.
`timescale 1ns/10ps
`include "nvmrw_map.svh"
module nvmrw_top import nvmrw_pkg::*; #(
	parameter int ERASE_CYC = `NVMRW_ERASE_CYC,
	parameter int PROG_CYC  = `NVMRW_PROG_CYC
) (
	input  wire logic        aclk,         // Core clock
	input  wire logic        aresetn,      // Sync reset, low
	input  wire logic        por_n,        // Power-on reset, low
	input  wire logic        ext_reset,    // External reset pin event
	input  wire logic        wdt_reset,    // Watchdog reset event
	input  wire logic [13:0] s_awaddr,     // AXI write address
	input  wire logic        s_awvalid,    // AXI
	output logic             s_awready,    // AXI
	input  wire logic [31:0] s_wdata,      // AXI
	input  wire logic [3:0]  s_wstrb,      // AXI
	input  wire logic        s_wvalid,     // AXI
	output logic             s_wready,     // AXI
	output logic [1:0]       s_bresp,      // AXI
	output logic             s_bvalid,     // AXI
	input  wire logic        s_bready,     // AXI
	input  wire logic [13:0] s_araddr,     // AXI read address
	input  wire logic        s_arvalid,    // AXI
	output logic             s_arready,    // AXI
	output logic [31:0]      s_rdata,      // AXI
	output logic [1:0]       s_rresp,      // AXI
	output logic             s_rvalid,     // AXI
	input  wire logic        s_rready,     // AXI
	output nvmrw_req_t       arr_req,      // Array command
	input  nvmrw_rsp_t       arr_rsp,      // Array answer
	output logic             cpu_stall,    // Halts instruction fetch
	output logic             irq           // Level interrupt
);
	// ==========================================================
	// Reset classes
	// ==========================================================
	// Power-on clears all but the AXI front end; warm resets keep data regs and error flag
	logic warm_rst, any_rst, cold_rst;
	assign cold_rst = !por_n;
	assign warm_rst = ext_reset || wdt_reset;
	assign any_rst  = !aresetn || cold_rst || warm_rst;

	// ==========================================================
	// Register state
	// ==========================================================
	logic [7:0] data_lo_q, data_hi_q, addr_lo_q, addr_hi_q;
	logic       mem_sel_q, wr_en_q, wr_trig_q, rd_trig_q, wr_err_q;
	logic [1:0] irq_stat_q, irq_mask_q;
	logic       wr_stb, wr_ok, rd_ok;
	logic [11:0] wr_idx, rd_idx;
	logic [7:0] wr_byte, rd_byte;
	typedef enum logic [2:0] {S_IDLE, S_READ, S_ERASE, S_PROG} nvmrw_seq_t;
	nvmrw_seq_t state_q;
	logic       busy, start_wr, start_rd, t_start, t_exp, write_done, read_done;
	logic [15:0] t_cycles;
	assign busy = (state_q != S_IDLE);

	nvmrw_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_awaddr),
		.awvalid (s_awvalid),
		.awready (s_awready),
		.wdata   (s_wdata),
		.wstrb   (s_wstrb),
		.wvalid  (s_wvalid),
		.wready  (s_wready),
		.bresp   (s_bresp),
		.bvalid  (s_bvalid),
		.bready  (s_bready),
		.araddr  (s_araddr),
		.arvalid (s_arvalid),
		.arready (s_arready),
		.rdata   (s_rdata),
		.rresp   (s_rresp),
		.rvalid  (s_rvalid),
		.rready  (s_rready),
		.wr_stb  (wr_stb),
		.wr_idx  (wr_idx),
		.wr_byte (wr_byte),
		.wr_ok   (wr_ok),
		.rd_idx  (rd_idx),
		.rd_byte (rd_byte),
		.rd_ok   (rd_ok)
	);

	assign wr_ok = (wr_idx == `NVMRW_IDX_DATA_LOW) || (wr_idx == `NVMRW_IDX_ADDR_LOW)
		|| (wr_idx == `NVMRW_IDX_DATA_HIGH) || (wr_idx == `NVMRW_IDX_ADDR_HIGH)
		|| (wr_idx == `NVMRW_IDX_CONTROL) || (wr_idx == `NVMRW_IDX_CTRL_AUX)
		|| (wr_idx == `NVMRW_IDX_IRQ_STATUS) || (wr_idx == `NVMRW_IDX_IRQ_MASK);

	logic ctl_wr;
	assign ctl_wr = wr_stb && (wr_idx == `NVMRW_IDX_CONTROL);

	// ==========================================================
	// Data and address registers
	// ==========================================================
	// Warm reset keeps
	always_ff @(posedge aclk) begin
		if (cold_rst) begin
			data_lo_q <= `NVMRW_RST_BYTE;
			data_hi_q <= `NVMRW_RST_BYTE;
			addr_lo_q <= `NVMRW_RST_BYTE;
			addr_hi_q <= `NVMRW_RST_BYTE;
		end else begin
			if (read_done) begin
				data_lo_q <= arr_rsp.rdata[7:0];
				data_hi_q <= mem_sel_q ? arr_rsp.rdata[15:8] : data_hi_q;
			end else if (wr_stb && !busy) begin
				if (wr_idx == `NVMRW_IDX_DATA_LOW)
					data_lo_q <= wr_byte;
				if (wr_idx == `NVMRW_IDX_DATA_HIGH)
					data_hi_q <= wr_byte;
				if (wr_idx == `NVMRW_IDX_ADDR_LOW)
					addr_lo_q <= wr_byte;
				if (wr_idx == `NVMRW_IDX_ADDR_HIGH)
					addr_hi_q <= wr_byte;
			end
		end
	end

	// ==========================================================
	// Memory select
	// ==========================================================
	// Frozen while busy
	always_ff @(posedge aclk) begin
		if (cold_rst)
			mem_sel_q <= 1'b0;
		else if (ctl_wr && !busy && !warm_rst && aresetn)
			mem_sel_q <= wr_byte[`NVMRW_BIT_MEM_SEL];
	end

	// ==========================================================
	// Enables and triggers
	// ==========================================================
	// Trigger refused without enable
	assign start_wr = ctl_wr && wr_byte[`NVMRW_BIT_WR_TRIG] && wr_en_q && !busy;
	// Only a written one starts a read
	assign start_rd = ctl_wr && wr_byte[`NVMRW_BIT_RD_TRIG] && !busy && !start_wr;

	// Any reset clears enable and triggers
	always_ff @(posedge aclk) begin
		if (any_rst) begin
			wr_en_q   <= 1'b0;
			wr_trig_q <= 1'b0;
			rd_trig_q <= 1'b0;
		end else begin
			if (ctl_wr)
				wr_en_q <= wr_byte[`NVMRW_BIT_WR_EN];
			// Set by software, cleared by hardware
			if (start_wr)
				wr_trig_q <= 1'b1;
			else if (write_done)
				wr_trig_q <= 1'b0;
			if (start_rd)
				rd_trig_q <= 1'b1;
			else if (read_done)
				rd_trig_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (cold_rst)
			wr_err_q <= 1'b0;
		else if (warm_rst && wr_trig_q)
			wr_err_q <= 1'b1;
		else if (ctl_wr && aresetn)
			wr_err_q <= wr_byte[`NVMRW_BIT_WR_ERR];
	end

	// ==========================================================
	// Sequencer
	// ==========================================================
	nvmrw_timer #(.W(16)) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn && !warm_rst && !cold_rst),
		.start   (t_start),
		.cycles  (t_cycles),
		.expire  (t_exp)
	);
	assign t_start  = start_wr || (state_q == S_ERASE && t_exp);
	assign t_cycles = start_wr ? 16'(ERASE_CYC) : 16'(PROG_CYC);
	assign write_done = (state_q == S_PROG) && t_exp;
	assign read_done  = (state_q == S_READ) && arr_rsp.done;

	always_ff @(posedge aclk) begin
		if (any_rst)
			state_q <= S_IDLE;
		else begin
			unique case (state_q)
				S_IDLE: begin
					if (start_wr)
						state_q <= S_ERASE;
					else if (start_rd)
						state_q <= S_READ;
				end
				S_READ:  if (arr_rsp.done) state_q <= S_IDLE;
				S_ERASE: if (t_exp) state_q <= S_PROG;
				S_PROG:  if (t_exp) state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Array only sees erase/program while the write trigger is set
	always_comb begin
		arr_req.prog_mem = mem_sel_q;
		arr_req.addr     = mem_sel_q ? {addr_hi_q, addr_lo_q} : {8'h00, addr_lo_q};
		arr_req.wdata    = mem_sel_q ? {data_hi_q, data_lo_q} : {8'h00, data_lo_q};
		unique case (state_q)
			S_READ:  arr_req.op = NVMRW_ARR_READ;
			S_ERASE: arr_req.op = wr_trig_q ? NVMRW_ARR_ERASE : NVMRW_ARR_IDLE;
			S_PROG:  arr_req.op = wr_trig_q ? NVMRW_ARR_PROG : NVMRW_ARR_IDLE;
			default: arr_req.op = NVMRW_ARR_IDLE;
		endcase
	end

	// Core halted through a program-memory write
	assign cpu_stall = wr_trig_q && mem_sel_q;

	// ==========================================================
	// Interrupt status and mask
	// ==========================================================
	// Completion sets flag; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn || cold_rst) begin
			irq_stat_q <= `NVMRW_RST_IRQ;
			irq_mask_q <= `NVMRW_RST_IRQ;
		end else begin
			if (wr_stb && wr_idx == `NVMRW_IDX_IRQ_MASK)
				irq_mask_q <= wr_byte[1:0];
			irq_stat_q[`NVMRW_IRQ_WR_DONE] <= write_done || (irq_stat_q[`NVMRW_IRQ_WR_DONE]
				&& !(wr_stb && wr_idx == `NVMRW_IDX_IRQ_STATUS && wr_byte[`NVMRW_IRQ_WR_DONE]));
			irq_stat_q[`NVMRW_IRQ_WR_ERR] <= (warm_rst && wr_trig_q) || (irq_stat_q[`NVMRW_IRQ_WR_ERR]
				&& !(wr_stb && wr_idx == `NVMRW_IDX_IRQ_STATUS && wr_byte[`NVMRW_IRQ_WR_ERR]));
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	// ==========================================================
	// Read mux
	// ==========================================================
	// Unimplemented control bits read zero
	always_comb begin
		rd_ok   = 1'b1;
		rd_byte = 8'h00;
		unique case (rd_idx)
			`NVMRW_IDX_DATA_LOW:   rd_byte = data_lo_q;
			`NVMRW_IDX_ADDR_LOW:   rd_byte = addr_lo_q;
			`NVMRW_IDX_DATA_HIGH:  rd_byte = data_hi_q;
			`NVMRW_IDX_ADDR_HIGH:  rd_byte = addr_hi_q;
			`NVMRW_IDX_CONTROL:    rd_byte = {mem_sel_q, 3'h0, wr_err_q, wr_en_q, wr_trig_q, rd_trig_q};
			`NVMRW_IDX_CTRL_AUX:   rd_byte = 8'h00;
			`NVMRW_IDX_IRQ_STATUS: rd_byte = {6'h00, irq_stat_q};
			`NVMRW_IDX_IRQ_MASK:   rd_byte = {6'h00, irq_mask_q};
			default:               rd_ok   = 1'b0;
		endcase
	end

	// ==========================================================
	// Checks
	// ==========================================================
	// Array phases in write order
	sequence erase_phase_s;
		state_q == S_ERASE;
	endsequence
	sequence prog_phase_s;
		state_q == S_PROG;
	endsequence

	no_write_unarmed_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctl_wr && !wr_en_q && state_q == S_IDLE) |=> (state_q != S_ERASE))
		else $error("write started without enable");
	trig_clears_a: assert property (@(posedge aclk) disable iff (any_rst)
		write_done |=> !wr_trig_q)
		else $error("write trigger not cleared");
	done_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn || cold_rst)
		write_done |=> irq_stat_q[`NVMRW_IRQ_WR_DONE])
		else $error("completion flag missing");
	erase_first_a: assert property (@(posedge aclk) disable iff (any_rst)
		start_wr |=> erase_phase_s)
		else $error("write did not begin with erase");
	stall_prog_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(arr_req.prog_mem && (arr_req.op == NVMRW_ARR_ERASE || arr_req.op == NVMRW_ARR_PROG)) |-> cpu_stall)
		else $error("core not stalled");
	stall_release_a: assert property (@(posedge aclk) disable iff (any_rst)
		write_done |=> !cpu_stall)
		else $error("core not resumed");
	erase_to_prog_a: assert property (@(posedge aclk) disable iff (any_rst)
		(state_q == S_ERASE && t_exp) |=> prog_phase_s)
		else $error("program phase did not follow erase");
	err_on_warm_a: assert property (@(posedge aclk) disable iff (cold_rst)
		(warm_rst && wr_trig_q) |=> wr_err_q)
		else $error("error flag not set");
	sel_frozen_a: assert property (@(posedge aclk) disable iff (cold_rst)
		busy |=> $stable(mem_sel_q))
		else $error("memory select changed while busy");
	reset_clears_a: assert property (@(posedge aclk)
		any_rst |=> (!wr_en_q && !wr_trig_q && !rd_trig_q))
		else $error("reset left enables set");

	// ==========================================================
	// Checks on register behaviour
	// ==========================================================
	read_self_clear_a: assert property (@(posedge aclk) disable iff (any_rst)
		read_done |=> !rd_trig_q)
		else $error("read trigger not cleared");
	trig_sticky_a: assert property (@(posedge aclk) disable iff (any_rst)
		(wr_trig_q && !write_done) |=> wr_trig_q)
		else $error("write trigger dropped early");
	inhibit_idle_a: assert property (@(posedge aclk) disable iff (any_rst)
		(state_q == S_IDLE && !wr_en_q) |=> (arr_req.op != NVMRW_ARR_ERASE))
		else $error("erase without write enable");
	warm_keeps_a: assert property (@(posedge aclk) disable iff (cold_rst)
		(warm_rst && !wr_stb && !read_done) |=> $stable({data_lo_q, data_hi_q, addr_lo_q, addr_hi_q, mem_sel_q}))
		else $error("warm reset disturbed registers");
	no_false_err_a: assert property (@(posedge aclk) disable iff (cold_rst)
		(!wr_trig_q && !ctl_wr) |=> $stable(wr_err_q))
		else $error("error flag changed without cause");
	ctrl_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_arvalid && s_arready && s_araddr[13:2] == `NVMRW_IDX_CONTROL) |=> (s_rdata[6:4] == 3'h0))
		else $error("unimplemented control bits set");
endmodule : nvmrw_top

// ==== nvmrw_map.svh ====
// Register offsets, field positions, reset values and timing counts of the nvm control block
`ifndef NVMRW_MAP_SVH
`define NVMRW_MAP_SVH
// Register indices as printed; byte address is four times the index
`define NVMRW_IDX_DATA_LOW   12'h10C
`define NVMRW_IDX_ADDR_LOW   12'h10D
`define NVMRW_IDX_DATA_HIGH  12'h10E
`define NVMRW_IDX_ADDR_HIGH  12'h10F
`define NVMRW_IDX_CONTROL    12'h18C
`define NVMRW_IDX_CTRL_AUX   12'h18D
`define NVMRW_IDX_IRQ_STATUS 12'h190
`define NVMRW_IDX_IRQ_MASK   12'h191
// Control register fields
`define NVMRW_BIT_RD_TRIG    0
`define NVMRW_BIT_WR_TRIG    1
`define NVMRW_BIT_WR_EN      2
`define NVMRW_BIT_WR_ERR     3
`define NVMRW_BIT_MEM_SEL    7
// Interrupt status fields
`define NVMRW_IRQ_WR_DONE    0
`define NVMRW_IRQ_WR_ERR     1
`define NVMRW_IRQ_W          2
// Reset values
`define NVMRW_RST_BYTE       8'h00
`define NVMRW_RST_IRQ        2'h0
// Timing: erase and program phase lengths in ns
`define NVMRW_ERASE_NS       2000
`define NVMRW_PROG_NS        2000
`define NVMRW_CLK_NS         4
`define NVMRW_ERASE_CYC      ((`NVMRW_ERASE_NS + `NVMRW_CLK_NS - 1) / `NVMRW_CLK_NS)
`define NVMRW_PROG_CYC       ((`NVMRW_PROG_NS + `NVMRW_CLK_NS - 1) / `NVMRW_CLK_NS)
`define NVMRW_READ_CYC       2
`endif

// ==== nvmrw_pkg.sv ====
// Types shared by the nvm control block
package nvmrw_pkg;
	typedef enum logic [1:0] {NVMRW_ARR_IDLE, NVMRW_ARR_READ, NVMRW_ARR_ERASE, NVMRW_ARR_PROG} nvmrw_op_t;
	typedef struct packed {
		nvmrw_op_t   op;
		logic        prog_mem;
		logic [15:0] addr;
		logic [15:0] wdata;
	} nvmrw_req_t;
	typedef struct packed {
		logic        done;
		logic [15:0] rdata;
	} nvmrw_rsp_t;
endpackage : nvmrw_pkg

// ==== nvmrw_timer.sv ====
// Cycle counter for one array phase
`timescale 1ns/10ps
module nvmrw_timer #(
	parameter int W = 16
) (
	input  wire logic         aclk,    // Core clock
	input  wire logic         aresetn, // Sync reset
	input  wire logic         start,   // Load count
	input  wire logic [W-1:0] cycles,  // Phase length
	output logic              expire   // Pulse at end
);
	logic [W-1:0] cnt_q;
	logic         run_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (start) begin
			cnt_q <= cycles;
			run_q <= 1'b1;
		end else if (run_q) begin
			cnt_q <= cnt_q - W'(1);
			if (cnt_q == W'(1))
				run_q <= 1'b0;
		end
	end
	assign expire = run_q && (cnt_q == W'(1));
endmodule : nvmrw_timer

// ==== nvmrw_axil.sv ====
// AXI4-Lite slave front end, one write and one read at a time
`timescale 1ns/10ps
module nvmrw_axil (
	input  wire logic        aclk,     // Core clock
	input  wire logic        aresetn,  // Sync reset
	input  wire logic [13:0] awaddr,   // Write address
	input  wire logic        awvalid,  // Write address valid
	output logic             awready,  // Write address ready
	input  wire logic [31:0] wdata,    // Write data
	input  wire logic [3:0]  wstrb,    // Byte enables
	input  wire logic        wvalid,   // Write data valid
	output logic             wready,   // Write data ready
	output logic [1:0]       bresp,    // Write response
	output logic             bvalid,   // Response valid
	input  wire logic        bready,   // Response ready
	input  wire logic [13:0] araddr,   // Read address
	input  wire logic        arvalid,  // Read address valid
	output logic             arready,  // Read address ready
	output logic [31:0]      rdata,    // Read data
	output logic [1:0]       rresp,    // Read response
	output logic             rvalid,   // Read valid
	input  wire logic        rready,   // Read ready
	output logic             wr_stb,   // Register write pulse
	output logic [11:0]      wr_idx,   // Register index
	output logic [7:0]       wr_byte,  // Low byte
	input  wire logic        wr_ok,    // Index mapped
	output logic [11:0]      rd_idx,   // Read index
	input  wire logic [7:0]  rd_byte,  // Read value
	input  wire logic        rd_ok     // Read index mapped
);
	logic        aw_have_q, w_have_q;
	logic [11:0] aw_idx_q;
	logic [7:0]  w_byte_q;
	logic        w_lane_q;
	assign awready = !aw_have_q && !bvalid;
	assign wready  = !w_have_q && !bvalid;
	assign arready = !rvalid;
	assign rd_idx  = araddr[13:2];
	assign wr_idx  = aw_idx_q;
	assign wr_byte = w_byte_q;
	assign wr_stb  = aw_have_q && w_have_q && w_lane_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_idx_q  <= 12'h000;
			w_byte_q  <= 8'h00;
			w_lane_q  <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= 2'h0;
		end else begin
			if (awvalid && awready) begin
				aw_have_q <= 1'b1;
				aw_idx_q  <= awaddr[13:2];
			end
			if (wvalid && wready) begin
				w_have_q <= 1'b1;
				w_byte_q <= wdata[7:0];
				w_lane_q <= wstrb[0];
			end
			if (aw_have_q && w_have_q) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid    <= 1'b1;
				// Unmapped index answers SLVERR
				bresp     <= wr_ok ? 2'h0 : 2'h2;
			end else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= 2'h0;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= {24'h00_0000, rd_byte};
			rresp  <= rd_ok ? 2'h0 : 2'h2;
		end else if (rvalid && rready)
			rvalid <= 1'b0;
	end
endmodule : nvmrw_axil

// ==== nvmrw_array_model.sv ====
// Behavioural model of the data and program arrays behind the nvm control block
`timescale 1ns/10ps
module nvmrw_array_model import nvmrw_pkg::*; (
	input  wire nvmrw_req_t arr_req,   // Command from block
	input  wire logic       aclk,      // Core clock
	output nvmrw_rsp_t      arr_rsp,   // Answer to block
	output int              erase_cnt, // Erase phases seen
	output int              read_cnt   // Reads started
);
	logic [15:0] mem [logic [16:0]];
	integer      mseed;
	int          lat;
	logic        busy;
	logic        answered;
	nvmrw_op_t   prev;
	wire  [16:0] key = {arr_req.prog_mem, arr_req.addr};
	initial begin
		mseed = 32'h0000_0B17;
		erase_cnt = 0;
		read_cnt = 0;
		busy = 1'b0;
		answered = 1'b0;
		prev = NVMRW_ARR_IDLE;
		lat = 0;
		arr_rsp = '0;
	end
	// ==========================================
	// Array behaviour
	always @(posedge aclk) begin
		arr_rsp.done <= 1'b0;
		// Idle read bus toggles so a stale capture cannot pass
		arr_rsp.rdata <= ~arr_rsp.rdata;
		prev <= arr_req.op;
		if (arr_req.op == NVMRW_ARR_ERASE) begin
			mem[key] = 16'hFFFF;
			if (prev != NVMRW_ARR_ERASE)
				erase_cnt <= erase_cnt + 1;
		end
		if (arr_req.op == NVMRW_ARR_PROG)
			mem[key] = arr_req.wdata;
		// Slow or prompt answer, one done pulse per read
		if (arr_req.op != NVMRW_ARR_READ) begin
			answered <= 1'b0;
		end else if (!busy && !answered) begin
			busy <= 1'b1;
			lat <= 1 + {$random(mseed)} % 3;
			read_cnt <= read_cnt + 1;
		end else if (busy && lat > 1) begin
			lat <= lat - 1;
		end else if (busy) begin
			busy <= 1'b0;
			answered <= 1'b1;
			arr_rsp.done <= 1'b1;
			arr_rsp.rdata <= mem.exists(key) ? mem[key] : 16'hFFFF;
		end
	end
endmodule : nvmrw_array_model

// ==== testbench.sv ====
// Self-checking testbench of the nvm control block
`timescale 1ns/10ps
`include "nvmrw_map.svh"
module testbench import nvmrw_pkg::*; ;
	localparam logic [13:0] A_DL = {`NVMRW_IDX_DATA_LOW, 2'b00};
	localparam logic [13:0] A_AL = {`NVMRW_IDX_ADDR_LOW, 2'b00};
	localparam logic [13:0] A_DH = {`NVMRW_IDX_DATA_HIGH, 2'b00};
	localparam logic [13:0] A_AH = {`NVMRW_IDX_ADDR_HIGH, 2'b00};
	localparam logic [13:0] A_CT = {`NVMRW_IDX_CONTROL, 2'b00};
	localparam logic [13:0] A_ST = {`NVMRW_IDX_IRQ_STATUS, 2'b00};
	localparam logic [13:0] A_MK = {`NVMRW_IDX_IRQ_MASK, 2'b00};
	logic        aclk = 0, aresetn = 0, por_n = 0, ext_reset = 0, wdt_reset = 0;
	logic [13:0] awaddr = 0, araddr = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0]  wstrb = 0;
	logic        awready, wready, bvalid, arready, rvalid, cpu_stall, irq;
	logic [1:0]  bresp, rresp, rsp;
	nvmrw_req_t  arr_req;
	nvmrw_rsp_t  arr_rsp;
	int          erase_cnt, read_cnt;
	int          fail_count = 0, comparisons = 0;
	integer      seed = 32'h2457;
	always #2 aclk = ~aclk;
	nvmrw_top #(.ERASE_CYC(3), .PROG_CYC(5)) dut_u (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
		.ext_reset(ext_reset), .wdt_reset(wdt_reset), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
		.s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
		.arr_req(arr_req), .arr_rsp(arr_rsp), .cpu_stall(cpu_stall), .irq(irq));
	nvmrw_array_model model_u (.arr_req(arr_req), .aclk(aclk), .arr_rsp(arr_rsp),
		.erase_cnt(erase_cnt), .read_cnt(read_cnt));
	// ==========================================
	// Checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task stop_test;
		$display("compares %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	function automatic logic [31:0] ctl(input logic sel, input logic err, input logic en);
		return {24'h0, sel, 3'b000, err, en, 2'b00};
	endfunction : ctl
	// ==========================================
	// AXI4-Lite master
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'($random(seed)), d};
		wstrb <= {3'($random(seed)), 1'b1};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// No cycle budget here; only the watchdog ends a stuck wait
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [13:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : rd
	// Polls until both triggers have dropped
	task automatic wait_idle;
		logic [31:0] v;
		do
			rd(A_CT, v);
		while (v[1:0] !== 2'b00);
	endtask : wait_idle
	// ==========================================
	// Scenarios
	initial begin
		logic [31:0] v;
		logic [7:0]  dl, al, dh, ah;
		int          n;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		por_n <= 1'b1;
		rd(A_CT, v);
		chk(v, 32'h0);
		rd(14'h3FFC, v);
		chk(32'(rsp), 32'h2);
		wr(14'h3FFC, 8'h00);
		chk(32'(rsp), 32'h2);
		wr(A_CT, 8'h70);
		chk(32'(rsp), 32'h0);
		rd(A_CT, v);
		chk(v, 32'h0);
		n = erase_cnt;
		wr(A_CT, 8'h02);
		repeat (20) @(posedge aclk);
		chk(erase_cnt, n);
		rd(A_CT, v);
		chk(v, 32'h0);
		wr(A_MK, 8'h03);
		// First pass is a corner case, then random data writes and reads
		for (int k = 0; k < 3; k++) begin
			dl = (k == 0) ? 8'h00 : 8'($random(seed));
			al = (k == 0) ? 8'hFF : 8'($random(seed));
			wr(A_DL, dl);
			wr(A_AL, al);
			wr(A_CT, 8'h04);
			wr(A_ST, 8'h03);
			n = erase_cnt;
			wr(A_CT, 8'h06);
			wait_idle;
			chk(erase_cnt, n + 1);
			chk(32'(irq), 32'h1);
			rd(A_ST, v);
			chk(v, 32'h1);
			rd(A_CT, v);
			chk(v, ctl(1'b0, 1'b0, 1'b1));
			n = read_cnt;
			wr(A_DL, ~dl);
			wr(A_CT, 8'h04);
			// Give a wrongly started read time to reach the array
			repeat (2) @(posedge aclk);
			chk(read_cnt, n);
			wr(A_CT, 8'h05);
			wait_idle;
			rd(A_DL, v);
			chk(v, {24'h0, dl});
		end
		wr(A_MK, 8'h00);
		chk(32'(irq), 32'h0);
		wr(A_MK, 8'h03);
		wr(A_ST, 8'h01);
		chk(32'(irq), 32'h0);
		// program write, select frozen while busy
		dl = 8'($random(seed));
		al = 8'($random(seed));
		dh = 8'($random(seed)) & 8'h3F;
		ah = 8'($random(seed)) & 8'h1F;
		wr(A_DL, dl);
		wr(A_AL, al);
		wr(A_DH, dh);
		wr(A_AH, ah);
		wr(A_CT, 8'h84);
		wr(A_CT, 8'h86);
		chk(32'(cpu_stall), 32'h1);
		wr(A_CT, 8'h04);
		wait_idle;
		chk(32'(cpu_stall), 32'h0);
		rd(A_CT, v);
		chk(v, ctl(1'b1, 1'b0, 1'b1));
		// Spoil the data registers so only the array read can restore them
		wr(A_DL, ~dl);
		wr(A_DH, ~dh);
		wr(A_CT, 8'h85);
		wait_idle;
		rd(A_DL, v);
		chk(v, {24'h0, dl});
		rd(A_DH, v);
		chk(v, {24'h0, dh});
		// warm reset in mid-write, both sources
		for (int k = 0; k < 2; k++) begin
			wr(A_CT, 8'h84);
			wr(A_CT, 8'h86);
			ext_reset <= (k == 0);
			wdt_reset <= (k == 1);
			@(posedge aclk);
			ext_reset <= 1'b0;
			wdt_reset <= 1'b0;
			repeat (2) @(posedge aclk);
			rd(A_CT, v);
			chk(v, ctl(1'b1, 1'b1, 1'b0));
			rd(A_DL, v);
			chk(v, {24'h0, dl});
			rd(A_AL, v);
			chk(v, {24'h0, al});
			rd(A_ST, v);
			chk(v & 32'h2, 32'h2);
			wr(A_ST, 8'h03);
			wr(A_CT, 8'h80);
		end
		por_n <= 1'b0;
		repeat (2) @(posedge aclk);
		por_n <= 1'b1;
		rd(A_CT, v);
		chk(v, 32'h0);
		rd(A_DL, v);
		chk(v, 32'h0);
		stop_test;
	end
	// Whole run needs a few hundred cycles
	initial begin
		#80000;
		fail_count++;
		stop_test;
	end
endmodule : testbench
